// >>> include/blc_pkg.sv
// constants and types for the boost and led sink control register bank
// assumes a two-wire serial host and a single 20 MHz synchronous clock domain
//
// Overview of operation
// - Boost configuration bit 7 picks LED mode at 0, standalone mode at 1.
// - Control bit 5 gates the boost output, only while standalone mode is chosen.
// - Control bits 4 to 1 individually switch sinks LED5, LED4, LED3, LED2.
// - A grouped channel ignores its individual enable and follows the group enable.
// - Control bit 0 switches every grouped backlight channel on or off.
// - Configuration bit 6 at 0: boost biases and regulates headroom on all active channels.
// - Configuration bit 6 at 1: boost biases only active grouped backlight channels.
// - The bias target choice counts only in LED mode, ignored in standalone mode.
// - Configuration bit 5 switches the backlight fade in and out override.
// - LED2 current register bit 7 puts LED2 in the group or keeps it individual.
package blc_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_LED_CTRL = 8'h26;
  localparam logic [7:0] ADDR_BOOST_CFG = 8'h27;
  localparam logic [7:0] ADDR_LED2_CUR = 8'h29;

  // ==========================================================
  // field positions
  localparam int CTRL_STANDALONE_ON = 5;
  localparam int CTRL_SINK_LSB = 1;
  localparam int CTRL_GROUP_ON = 0;
  localparam int CFG_MODE = 7;
  localparam int CFG_BIAS_TARGET = 6;
  localparam int CFG_FADE_OVR = 5;
  localparam int LED2_MEMBER = 7;

  // ==========================================================
  // writable bits and reset values
  localparam logic [7:0] LED_CTRL_MASK = 8'h3f;
  localparam logic [7:0] BOOST_CFG_MASK = 8'he0;
  localparam logic [7:0] LED2_CUR_MASK = 8'h80;
  localparam logic [7:0] LED_CTRL_RESET = 8'h00;
  localparam logic [7:0] BOOST_CFG_RESET = 8'h00;
  localparam logic [7:0] LED2_CUR_RESET = 8'h00;

  // ==========================================================
  // serial slave
  // value arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h3c;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int NUM_SINKS = 5;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WR,
    ST_ACK,
    ST_RD,
    ST_RACK
  } blc_i2c_state_t;

endpackage

// >>> include/blc_ctrl_if.sv
// control bits and derived sink and bias decisions between register file and router
// assumes both ends live in the same clock domain
`timescale 1ns/10ps

interface blc_ctrl_if;
  logic [7:0] ctrl;
  logic [7:0] cfg;
  logic [4:1] member;
  logic [4:0] sink_on;
  logic [4:0] bias_track;
  logic boost_run;

  modport regs (
    output ctrl,
    output cfg,
    output member,
    input sink_on,
    input bias_track,
    input boost_run
  );

  modport route (
    input ctrl,
    input cfg,
    input member,
    output sink_on,
    output bias_track,
    output boost_run
  );
endinterface

// >>> verilog/blc_sink_route.sv
// decides which sinks run and which ones the boost tracks
// assumes inputs come from registers; pure combinational
`timescale 1ns/10ps

module blc_sink_route
  import blc_pkg::*;
(
  blc_ctrl_if.route bus
);

  logic [4:0] on_w;
  logic [4:0] grouped_w;

  // ==========================================================
  // sink enables
  assign on_w[0] = bus.ctrl[CTRL_GROUP_ON];
  assign grouped_w[0] = 1'b1;

  genvar k;
  generate
    for (k = 1; k < NUM_SINKS; k++)
    begin : g_sink
      assign grouped_w[k] = bus.member[k];
      // grouped channel follows the group enable
      assign on_w[k] = bus.member[k] ? bus.ctrl[CTRL_GROUP_ON]
                                     : bus.ctrl[CTRL_SINK_LSB + k - 1];
    end
  endgenerate

  // ==========================================================
  // boost bias targets
  always_comb
  begin
    if (bus.cfg[CFG_MODE])
    begin
      bus.bias_track = 5'h00;
      bus.boost_run = bus.ctrl[CTRL_STANDALONE_ON];
    end
    else
    begin
      bus.bias_track = bus.cfg[CFG_BIAS_TARGET] ? (on_w & grouped_w)
                                                : on_w;
      bus.boost_run = |bus.bias_track;
    end
  end

  assign bus.sink_on = on_w;

endmodule // blc_sink_route

// >>> verilog/blc_regs_top.sv
// boost and led sink control registers behind a two-wire serial slave
// assumes scl and sda already synchronous to ref_clk_in; sda is open drain
`timescale 1ns/10ps

module blc_regs_top
  import blc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [2:0] upper_sinks_grouped_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic [4:0] sink_on_out,
  output logic [4:0] bias_track_out,
  output logic boost_run_out,
  output logic standalone_mode_out,
  output logic fade_override_out
);

  // ==========================================================
  // serial slave state
  blc_i2c_state_t st_reg, st_next;
  blc_i2c_state_t after_reg, after_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] ptr_reg, ptr_next;
  logic oe_reg, oe_next;
  logic nack_reg, nack_next;
  logic scl_q_reg, scl_q_next;
  logic sda_q_reg, sda_q_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] cfg_reg, cfg_next;
  logic [7:0] led2_reg, led2_next;

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  blc_ctrl_if bus ();

  // unmapped offsets read zero
  function automatic logic [7:0] reg_read(
    input logic [7:0] addr,
    input logic [7:0] ctrl,
    input logic [7:0] cfg,
    input logic [7:0] led2
  );
    case (addr)
      ADDR_LED_CTRL: reg_read = ctrl;
      ADDR_BOOST_CFG: reg_read = cfg;
      ADDR_LED2_CUR: reg_read = led2;
      default: reg_read = 8'h00;
    endcase
  endfunction

  assign scl_rise = scl_in & ~scl_q_reg;
  assign scl_fall = ~scl_in & scl_q_reg;
  assign start_seen = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
  assign stop_seen = scl_in & scl_q_reg & ~sda_q_reg & sda_in;

  // ==========================================================
  // slave next state
  always_comb
  begin
    logic [7:0] rd_byte;
    rd_byte = reg_read(ptr_reg, ctrl_reg, cfg_reg, led2_reg);
    st_next = st_reg;
    after_next = after_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    ptr_next = ptr_reg;
    oe_next = oe_reg;
    nack_next = nack_reg;
    scl_q_next = scl_in;
    sda_q_next = sda_in;
    ctrl_next = ctrl_reg;
    cfg_next = cfg_reg;
    led2_next = led2_reg;
    if (start_seen)
    begin
      st_next = ST_ADDR;
      cnt_next = 4'h0;
      oe_next = 1'b0;
    end
    else if (stop_seen)
    begin
      st_next = ST_IDLE;
      oe_next = 1'b0;
    end
    else
    begin
      case (st_reg)
        ST_ADDR, ST_PTR, ST_WR:
        begin
          if (scl_rise && cnt_reg != BYTE_BITS)
          begin
            sh_next = {sh_reg[6:0], sda_in};
            cnt_next = cnt_reg + 4'h1;
          end
          else if (scl_fall && cnt_reg == BYTE_BITS)
          begin
            cnt_next = 4'h0;
            st_next = ST_ACK;
            oe_next = 1'b1;
            case (st_reg)
              ST_ADDR:
              begin
                if (sh_reg[7:1] != DEV_ADDR)
                begin
                  st_next = ST_IDLE;
                  oe_next = 1'b0;
                end
                else
                begin
                  after_next = sh_reg[0] ? ST_RD : ST_PTR;
                end
              end
              ST_PTR:
              begin
                ptr_next = sh_reg;
                after_next = ST_WR;
              end
              default:
              begin
                // reserved bits masked off on write
                case (ptr_reg)
                  ADDR_LED_CTRL: ctrl_next = sh_reg & LED_CTRL_MASK;
                  ADDR_BOOST_CFG: cfg_next = sh_reg & BOOST_CFG_MASK;
                  ADDR_LED2_CUR: led2_next = sh_reg & LED2_CUR_MASK;
                  default: ctrl_next = ctrl_reg;
                endcase
                ptr_next = ptr_reg + 8'h01;
                after_next = ST_WR;
              end
            endcase
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            st_next = after_reg;
            oe_next = 1'b0;
            if (after_reg == ST_RD)
            begin
              oe_next = ~rd_byte[7];
              sh_next = {rd_byte[6:0], 1'b0};
              cnt_next = 4'h1;
              ptr_next = ptr_reg + 8'h01;
            end
          end
        end
        ST_RD:
        begin
          if (scl_fall)
          begin
            if (cnt_reg == BYTE_BITS)
            begin
              oe_next = 1'b0;
              cnt_next = 4'h0;
              st_next = ST_RACK;
            end
            else
            begin
              oe_next = ~sh_reg[7];
              sh_next = {sh_reg[6:0], 1'b0};
              cnt_next = cnt_reg + 4'h1;
            end
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
          begin
            nack_next = sda_in;
          end
          else if (scl_fall)
          begin
            if (nack_reg)
            begin
              st_next = ST_IDLE;
            end
            else
            begin
              st_next = ST_RD;
              oe_next = ~rd_byte[7];
              sh_next = {rd_byte[6:0], 1'b0};
              cnt_next = 4'h1;
              ptr_next = ptr_reg + 8'h01;
            end
          end
        end
        default:
        begin
          st_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      st_reg <= ST_IDLE;
      after_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      oe_reg <= 1'b0;
      nack_reg <= 1'b0;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      ctrl_reg <= LED_CTRL_RESET;
      cfg_reg <= BOOST_CFG_RESET;
      led2_reg <= LED2_CUR_RESET;
    end
    else
    begin
      st_reg <= st_next;
      after_reg <= after_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      ptr_reg <= ptr_next;
      oe_reg <= oe_next;
      nack_reg <= nack_next;
      scl_q_reg <= scl_q_next;
      sda_q_reg <= sda_q_next;
      ctrl_reg <= ctrl_next;
      cfg_reg <= cfg_next;
      led2_reg <= led2_next;
    end
  end

  // ==========================================================
  // routing of control bits
  assign bus.ctrl = ctrl_reg;
  assign bus.cfg = cfg_reg;
  assign bus.member = {upper_sinks_grouped_in, led2_reg[LED2_MEMBER]};

  blc_sink_route u_route (
    .bus(bus.route)
  );

  // ==========================================================
  // registered outputs
  logic [4:0] sink_on_reg, sink_on_next;
  logic [4:0] bias_reg, bias_next;
  logic boost_reg, boost_next;
  logic mode_reg, mode_next;
  logic fade_reg, fade_next;
  logic sda_drv_reg, sda_drv_next;

  always_comb
  begin
    sink_on_next = bus.sink_on;
    bias_next = bus.bias_track;
    boost_next = bus.boost_run;
    mode_next = cfg_reg[CFG_MODE];
    fade_next = cfg_reg[CFG_FADE_OVR];
    // open drain only ever pulls low
    sda_drv_next = 1'b0;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      sink_on_reg <= 5'h00;
      bias_reg <= 5'h00;
      boost_reg <= 1'b0;
      mode_reg <= 1'b0;
      fade_reg <= 1'b0;
      sda_drv_reg <= 1'b0;
    end
    else
    begin
      sink_on_reg <= sink_on_next;
      bias_reg <= bias_next;
      boost_reg <= boost_next;
      mode_reg <= mode_next;
      fade_reg <= fade_next;
      sda_drv_reg <= sda_drv_next;
    end
  end

  assign sink_on_out = sink_on_reg;
  assign bias_track_out = bias_reg;
  assign boost_run_out = boost_reg;
  assign standalone_mode_out = mode_reg;
  assign fade_override_out = fade_reg;
  assign sda_out = sda_drv_reg;
  assign sda_oe_out = oe_reg;

  // ==========================================================
  // checks
  mode_follow_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    standalone_mode_out == $past(cfg_reg[CFG_MODE]))
    else $error("mode output does not follow boost config bit 7");

  boost_gate_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cfg_reg[CFG_MODE] |=> boost_run_out == $past(ctrl_reg[CTRL_STANDALONE_ON]))
    else $error("standalone boost output not gated by its enable");

  sink_single_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (!upper_sinks_grouped_in[0] && ctrl_reg[CTRL_SINK_LSB + 1])
    |=> sink_on_out[2])
    else $error("individual sink 3 not switched on");

  group_follow_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    led2_reg[LED2_MEMBER] |=> sink_on_out[1] == $past(ctrl_reg[CTRL_GROUP_ON]))
    else $error("grouped sink 2 does not follow group enable");

  group_on_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $rose(ctrl_reg[CTRL_GROUP_ON]) |=> sink_on_out[0] ##1 sink_on_out[0] == ctrl_reg[0])
    else $error("grouped backlight enable not applied");

  bias_all_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (!cfg_reg[CFG_MODE] && !cfg_reg[CFG_BIAS_TARGET]) |=> bias_track_out == sink_on_out)
    else $error("boost does not track every active sink");

  bias_group_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (!cfg_reg[CFG_MODE] && cfg_reg[CFG_BIAS_TARGET] && !led2_reg[LED2_MEMBER])
    |=> !bias_track_out[1] && bias_track_out[0] == sink_on_out[0])
    else $error("boost tracks a sink outside the group");

  bias_standalone_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    cfg_reg[CFG_MODE] |=> bias_track_out == 5'h00)
    else $error("bias target used in standalone mode");

  fade_follow_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    $changed(cfg_reg[CFG_FADE_OVR]) |=> fade_override_out == $past(cfg_reg[CFG_FADE_OVR]))
    else $error("fade override output lags its bit");

  member_sel_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (!led2_reg[LED2_MEMBER]) |=> sink_on_out[1] == $past(ctrl_reg[CTRL_SINK_LSB]))
    else $error("individual sink 2 ignores its own enable");

  reserved_zero_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    ((ctrl_reg & ~LED_CTRL_MASK) == 8'h00) && ((cfg_reg & ~BOOST_CFG_MASK) == 8'h00)
    && ((led2_reg & ~LED2_CUR_MASK) == 8'h00))
    else $error("reserved register bit set");

endmodule // blc_regs_top

// >>> sim/blc_host_model.sv
// two-wire serial host model driving the register bank from the far side
// assumes an external pull-up resolves sda; the model only pulls low or releases
`timescale 1ns/10ps

module blc_host_model
(
  input wire logic ref_clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_pull_out
);
  // ==========================================================
  // timing
  // each scl phase spans several ref clocks, above the two the slave needs
  localparam int HALF = 4;

  initial
  begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end

  task automatic wait_clks(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  // ==========================================================
  // bus conditions
  // one clock of hold after scl falls so sda never moves with it
  task automatic start_cond();
    wait_clks(1);
    sda_pull_out = 1'b0;
    wait_clks(HALF);
    scl_out = 1'b1;
    wait_clks(HALF);
    sda_pull_out = 1'b1;
    wait_clks(HALF);
    scl_out = 1'b0;
  endtask

  task automatic stop_cond();
    wait_clks(1);
    sda_pull_out = 1'b1;
    wait_clks(HALF);
    scl_out = 1'b1;
    wait_clks(HALF);
    sda_pull_out = 1'b0;
    wait_clks(HALF);
  endtask

  task automatic clock_bit(input logic b, output logic got);
    wait_clks(1);
    sda_pull_out = ~b;
    wait_clks(HALF);
    scl_out = 1'b1;
    wait_clks(HALF);
    got = sda_in;
    scl_out = 1'b0;
  endtask

  // ==========================================================
  // byte transfers, msb first
  task automatic send_byte(input logic [7:0] b, output logic acked);
    logic a;
    for (int i = 7; i >= 0; i--) clock_bit(b[i], a);
    clock_bit(1'b1, a);
    acked = ~a;
  endtask

  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic a;
    for (int i = 7; i >= 0; i--) clock_bit(1'b1, b[i]);
    clock_bit(~ack, a);
  endtask
endmodule // blc_host_model

// >>> sim/blc_regs_top_test.sv
// self-checking bench for the boost and led sink control register bank
// assumes the host model as the only serial master and a pull-up on sda
`timescale 1ns/10ps

module blc_regs_top_test
  import blc_pkg::*;
;
  logic ref_clk_in;
  logic rst_in = 1'b1;
  logic [2:0] grp = 3'h0;
  logic scl;
  logic host_pull;
  logic sda_wire;
  logic sda_out;
  logic sda_oe;
  logic [4:0] sink_on;
  logic [4:0] bias_track;
  logic boost_run;
  logic standalone;
  logic fade;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;

  logic [7:0] addr_tab [4] = '{ADDR_LED_CTRL, ADDR_BOOST_CFG, 8'h28, ADDR_LED2_CUR};
  logic [7:0] mask_tab [4] = '{8'h3f, 8'he0, 8'h00, 8'h80};
  logic [7:0] ctrl_tab [8] = '{8'h3f, 8'h1e, 8'h01, 8'h1f, 8'h1e, 8'h20, 8'h1f, 8'h3f};
  logic [7:0] cfg_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h40, 8'h80, 8'hc0, 8'h20};
  logic mem_tab [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic [2:0] grp_tab [8] = '{3'h0, 3'h7, 3'h5, 3'h2, 3'h0, 3'h0, 3'h0, 3'h3};

  // open drain wire with pull-up
  assign sda_wire = ~(host_pull | sda_oe);

  blc_host_model host_u (
    .ref_clk_in(ref_clk_in),
    .sda_in(sda_wire),
    .scl_out(scl),
    .sda_pull_out(host_pull)
  );

  blc_regs_top dut_u (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .scl_in(scl),
    .sda_in(sda_wire),
    .upper_sinks_grouped_in(grp),
    .sda_out(sda_out),
    .sda_oe_out(sda_oe),
    .sink_on_out(sink_on),
    .bias_track_out(bias_track),
    .boost_run_out(boost_run),
    .standalone_mode_out(standalone),
    .fade_override_out(fade)
  );

  initial
  begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  // ==========================================================
  // reporting
  task automatic close_out();
    if (num_errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ceiling several times the roughly 14k cycles the sequence needs
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      num_errors++;
      close_out();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  // ==========================================================
  // register access
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    logic k0;
    logic k1;
    logic k2;
    host_u.start_cond();
    host_u.send_byte({DEV_ADDR, 1'b0}, k0);
    host_u.send_byte(a, k1);
    host_u.send_byte(d, k2);
    host_u.stop_cond();
    check({7'h00, k0 & k1 & k2}, 8'h01);
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    logic k;
    logic [7:0] d;
    host_u.start_cond();
    host_u.send_byte({DEV_ADDR, 1'b0}, k);
    host_u.send_byte(a, k);
    host_u.start_cond();
    host_u.send_byte({DEV_ADDR, 1'b1}, k);
    host_u.recv_byte(1'b0, d);
    host_u.stop_cond();
    check(d, exp);
  endtask

  // returns {boost run, bias track, sink on}; grouped[0] is LED2
  function automatic logic [10:0] expect_route(input logic [7:0] c, input logic [7:0] g,
                                               input logic [3:0] grouped);
    logic [4:0] s;
    logic [4:0] b;
    s[0] = c[0];
    for (int i = 1; i < 5; i++) s[i] = grouped[i-1] ? c[0] : c[i];
    // standalone mode tracks no channel at all
    b = g[7] ? 5'h00 : (g[6] ? (s & {grouped, 1'b1}) : s);
    return {g[7] ? c[5] : |b, b, s};
  endfunction

  // ==========================================================
  // main sequence
  initial
  begin
    logic [10:0] e;
    logic k;
    logic [7:0] d;
    tick(8);
    rst_in = 1'b0;
    tick(1);
    check({3'h0, sink_on}, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      rd_check(addr_tab[i], 8'h00);
      reg_write(addr_tab[i], 8'hff);
      rd_check(addr_tab[i], mask_tab[i]);
      reg_write(addr_tab[i], 8'h00);
    end
    for (int i = 0; i < 8; i++)
    begin
      grp = grp_tab[i];
      reg_write(ADDR_LED2_CUR, {mem_tab[i], 7'h00});
      reg_write(ADDR_BOOST_CFG, cfg_tab[i]);
      reg_write(ADDR_LED_CTRL, ctrl_tab[i]);
      tick(2);
      e = expect_route(ctrl_tab[i], cfg_tab[i], {grp_tab[i], mem_tab[i]});
      check({3'h0, sink_on}, {3'h0, e[4:0]});
      check({3'h0, bias_track}, {3'h0, e[9:5]});
      check({7'h00, boost_run}, {7'h00, e[10]});
      check({7'h00, standalone}, {7'h00, cfg_tab[i][7]});
      check({7'h00, fade}, {7'h00, cfg_tab[i][5]});
    end
    // pointer advances per data byte within one write
    host_u.start_cond();
    host_u.send_byte({DEV_ADDR, 1'b0}, k);
    host_u.send_byte(ADDR_LED_CTRL, k);
    host_u.send_byte(8'h15, k);
    host_u.send_byte(8'ha0, k);
    host_u.stop_cond();
    rd_check(ADDR_LED_CTRL, 8'h15);
    rd_check(ADDR_BOOST_CFG, 8'ha0);
    // burst read: master ack continues at the next offset
    host_u.start_cond();
    host_u.send_byte({DEV_ADDR, 1'b0}, k);
    host_u.send_byte(ADDR_LED_CTRL, k);
    host_u.start_cond();
    host_u.send_byte({DEV_ADDR, 1'b1}, k);
    host_u.recv_byte(1'b1, d);
    check(d, 8'h15);
    host_u.recv_byte(1'b0, d);
    check(d, 8'ha0);
    host_u.stop_cond();
    // foreign slave address must leave registers untouched
    host_u.start_cond();
    host_u.send_byte({DEV_ADDR ^ 7'h01, 1'b0}, k);
    check({7'h00, k}, 8'h00);
    host_u.send_byte(ADDR_LED_CTRL, k);
    host_u.send_byte(8'hff, k);
    host_u.stop_cond();
    rd_check(ADDR_LED_CTRL, 8'h15);
    // reset in mid-run clears every control bit
    rst_in = 1'b1;
    tick(2);
    rst_in = 1'b0;
    tick(1);
    check({3'h0, sink_on}, 8'h00);
    check({7'h00, fade}, 8'h00);
    check({7'h00, sda_out}, 8'h00);
    rd_check(ADDR_BOOST_CFG, 8'h00);
    close_out();
  end
endmodule // blc_regs_top_test
